// File: design/iodb_bridge.sv
/*
  System-bus bridge: internal I/O range steering, PCI memory window translation and
  mechanism-1 configuration address/data registers.
  Assumes the processor holds a request for one cycle and waits for done before the next;
  the PCI side and I/O units answer with one-cycle ack pulses carrying read data.
*/
// Functional notes
// RQ1: Internal I/O ranges accept 16-bit transfers only.
// RQ2: Route GPIO low, select unit, GPIO high ranges.
// RQ3: Route power/irq, serial, parallel ranges.
// RQ4: Reserved range; route PS/2 and PWM.
// RQ5: Window from base bits 23:16 to fixed end.
// RQ6: PCI address: base top byte, bus low 24.
// RQ7: Window accesses become PCI memory cycles.
// RQ8: Config address and data registers, mechanism one.
// RQ9: Address register fields, enable, reset zero.
// RQ10: Enable gates cycles; reserved bits read zero.
// RQ11: Slot zero; function 0 host, 1 USB.
// RQ12: Software writes dword register index bits 7:2.
// RQ13: Enabled data access issues config read/write.
// RQ14: Disabled data access issues no cycle.
`timescale 1ns/1ps
module iodb_bridge (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire iodb_pkg::iodb_sreq_s  sreq,
  output logic                       sdone,
  output logic                       serr,
  output logic [31:0]                srdata,
  input  wire logic [31:0]           mem_base,
  output iodb_pkg::iodb_preq_s       preq,
  input  wire logic                  pack,
  input  wire logic [31:0]           prdata,
  output iodb_pkg::iodb_ioreq_s      ioreq,
  input  wire logic                  ioack,
  input  wire logic [15:0]           iordata
);
  import iodb_pkg::*;

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    IODB_S_IDLE = 2'b00,
    IODB_S_PCI  = 2'b01,
    IODB_S_IO   = 2'b10
  } iodb_state_e;

  iodb_state_e  state_r;
  logic [31:0]  cfg_addr_r;
  iodb_target_e tgt;
  logic [31:0]  win_start;
  logic         in_win;
  logic         is_cfg_a;
  logic         is_cfg_d;
  logic         cfg_valid;

  iodb_io_decode u_dec (
    .addr (sreq.addr),
    .tgt  (tgt)
  );

  // ---------------------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------------------
  always_comb begin
    win_start = {8'h0a, mem_base[23:16], 16'h0000};                     // [RQ5]
    in_win    = (sreq.addr >= win_start) && (sreq.addr <= IODB_WIN_LAST);  // [RQ5]
    is_cfg_a  = (sreq.addr == IODB_CFG_ADDR_REG);                       // [RQ8]
    is_cfg_d  = (sreq.addr == IODB_CFG_DATA_REG);                       // [RQ8]
    // Only slot zero with function 0 or 1 has a target behind it.
    cfg_valid = cfg_addr_r[IODB_CFG_EN_BIT] && (cfg_addr_r[15:11] == IODB_SLOT_USED)
                && ((cfg_addr_r[10:8] == IODB_FN_HOSTCTL) || (cfg_addr_r[10:8] == IODB_FN_USBCFG));  // [RQ11]
  end

  // ---------------------------------------------------------------------------
  // Configuration address register
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg_addr_r <= IODB_CFG_ADDR_RST;                                  // [RQ9]
    end else if (state_r == IODB_S_IDLE && sreq.req && sreq.wr && is_cfg_a
                 && sreq.size == IODB_SIZE_WORD) begin
      cfg_addr_r <= sreq.wdata & IODB_CFG_ADDR_WMSK;                    // [RQ9] [RQ10] [RQ12]
    end
  end

  // ---------------------------------------------------------------------------
  // Transaction sequencer
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= IODB_S_IDLE;
      sdone   <= 1'b0;
      serr    <= 1'b0;
      srdata  <= 32'h0000_0000;
      preq    <= '0;
      ioreq   <= '0;
    end else begin
      sdone     <= 1'b0;
      serr      <= 1'b0;
      preq.req  <= 1'b0;
      ioreq.req <= 1'b0;
      unique case (state_r)
        IODB_S_IDLE: begin
          if (sreq.req) begin
            if (is_cfg_a) begin
              sdone  <= 1'b1;
              serr   <= (sreq.size != IODB_SIZE_WORD);
              srdata <= sreq.wr ? 32'h0000_0000 : cfg_addr_r;           // [RQ10]
            end else if (is_cfg_d) begin
              if (cfg_valid && sreq.size == IODB_SIZE_WORD) begin
                preq.req   <= 1'b1;                                     // [RQ13]
                preq.cfg   <= 1'b1;
                preq.wr    <= sreq.wr;
                preq.addr  <= {24'h00_0000, cfg_addr_r[7:2], 2'b00} | {16'h0000, 5'h00, cfg_addr_r[10:8], 8'h00};
                preq.wdata <= sreq.wdata;
                state_r    <= IODB_S_PCI;
              end else begin
                // Disabled or unused function: answered locally, reads as all ones.
                sdone  <= 1'b1;                                         // [RQ14]
                serr   <= (sreq.size != IODB_SIZE_WORD);
                srdata <= 32'hffff_ffff;
              end
            end else if (in_win) begin
              preq.req   <= 1'b1;                                       // [RQ7]
              preq.cfg   <= 1'b0;
              preq.wr    <= sreq.wr;
              preq.addr  <= {mem_base[31:24], sreq.addr[23:0]};         // [RQ6]
              preq.wdata <= sreq.wdata;
              state_r    <= IODB_S_PCI;
            end else if (tgt != IODB_T_NONE && tgt != IODB_T_RSV && sreq.size == IODB_SIZE_HALF) begin
              ioreq.req   <= 1'b1;                                      // [RQ2] [RQ3] [RQ4]
              ioreq.wr    <= sreq.wr;
              ioreq.tgt   <= tgt;
              ioreq.offs  <= sreq.addr[7:0];
              ioreq.wdata <= sreq.wdata[15:0];
              state_r     <= IODB_S_IO;
            end else begin
              // Reserved, unmapped or wrong-width access: finishes with an error, no side effect.
              sdone  <= 1'b1;                                           // [RQ1] [RQ4]
              serr   <= 1'b1;
              srdata <= 32'h0000_0000;
            end
          end
        end
        IODB_S_PCI: begin
          if (pack) begin
            sdone   <= 1'b1;
            srdata  <= preq.wr ? 32'h0000_0000 : prdata;                // [RQ13]
            state_r <= IODB_S_IDLE;
          end
        end
        IODB_S_IO: begin
          if (ioack) begin
            sdone   <= 1'b1;
            srdata  <= {16'h0000, (ioreq.wr ? 16'h0000 : iordata)};     // [RQ1]
            state_r <= IODB_S_IDLE;
          end
        end
        default: state_r <= IODB_S_IDLE;
      endcase
    end
  end

endmodule // iodb_bridge

// File: design/iodb_io_decode.sv
/*
  Combinational decoder of the fixed internal I/O ranges.
  Assumes a full 32-bit physical address; output is registered by the caller.
*/
`timescale 1ns/1ps
module iodb_io_decode (
  input  wire logic [31:0]           addr,
  output iodb_pkg::iodb_target_e     tgt
);
  import iodb_pkg::*;

  function automatic logic in_rng(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  always_comb begin
    tgt = IODB_T_NONE;
    if (in_rng(addr, IODB_GPIO_LO_BASE, IODB_GPIO_LO_LAST)) tgt = IODB_T_GPIO_LO;  // [RQ2]
    if (in_rng(addr, IODB_PSEL_BASE, IODB_PSEL_LAST))       tgt = IODB_T_PSEL;     // [RQ2]
    if (in_rng(addr, IODB_GPIO_HI_BASE, IODB_GPIO_HI_LAST)) tgt = IODB_T_GPIO_HI;  // [RQ2]
    if (in_rng(addr, IODB_PMIRQ_BASE, IODB_PMIRQ_LAST))     tgt = IODB_T_PMIRQ;    // [RQ3]
    if (in_rng(addr, IODB_SER_BASE, IODB_SER_LAST))         tgt = IODB_T_SER;      // [RQ3]
    if (in_rng(addr, IODB_PAR_BASE, IODB_PAR_LAST))         tgt = IODB_T_PAR;      // [RQ3]
    if (in_rng(addr, IODB_RSV_BASE, IODB_RSV_LAST))         tgt = IODB_T_RSV;      // [RQ4]
    if (in_rng(addr, IODB_PS2_BASE, IODB_PS2_LAST))         tgt = IODB_T_PS2;      // [RQ4]
    if (in_rng(addr, IODB_PWM_BASE, IODB_PWM_LAST))         tgt = IODB_T_PWM;      // [RQ4]
  end

endmodule // iodb_io_decode

// File: design/iodb_pkg.sv
/*
  Package for the system-bus I/O decoder and PCI memory window bridge.
  Holds address ranges, register addresses, field positions, reset values and bus structs.
  Assumes a single 100 MHz clock domain with synchronous active-high reset.
*/
package iodb_pkg;

  // ---------------------------------------------------------------------------
  // Internal I/O ranges (inclusive bounds)
  // ---------------------------------------------------------------------------
  localparam logic [31:0] IODB_GPIO_LO_BASE  = 32'h1500_1080;
  localparam logic [31:0] IODB_GPIO_LO_LAST  = 32'h1500_108f;
  localparam logic [31:0] IODB_PSEL_BASE     = 32'h1500_1090;
  localparam logic [31:0] IODB_PSEL_LAST     = 32'h1500_10bf;
  localparam logic [31:0] IODB_GPIO_HI_BASE  = 32'h1500_10c0;
  localparam logic [31:0] IODB_GPIO_HI_LAST  = 32'h1500_10cf;
  localparam logic [31:0] IODB_PMIRQ_BASE    = 32'h1500_3800;
  localparam logic [31:0] IODB_PMIRQ_LAST    = 32'h1500_380f;
  localparam logic [31:0] IODB_SER_BASE      = 32'h1500_3810;
  localparam logic [31:0] IODB_SER_LAST      = 32'h1500_381f;
  localparam logic [31:0] IODB_PAR_BASE      = 32'h1500_3820;
  localparam logic [31:0] IODB_PAR_LAST      = 32'h1500_383f;
  localparam logic [31:0] IODB_RSV_BASE      = 32'h1500_3840;
  localparam logic [31:0] IODB_RSV_LAST      = 32'h1500_386f;
  localparam logic [31:0] IODB_PS2_BASE      = 32'h1500_3870;
  localparam logic [31:0] IODB_PS2_LAST      = 32'h1500_387f;
  localparam logic [31:0] IODB_PWM_BASE      = 32'h1500_3880;
  localparam logic [31:0] IODB_PWM_LAST      = 32'h1500_388f;

  // ---------------------------------------------------------------------------
  // PCI memory window and configuration registers
  // ---------------------------------------------------------------------------
  localparam logic [31:0] IODB_WIN_LAST      = 32'h0afe_ffff;
  localparam logic [31:0] IODB_CFG_ADDR_REG  = 32'h0aff_0cf8;
  localparam logic [31:0] IODB_CFG_DATA_REG  = 32'h0aff_0cfc;
  localparam logic [31:0] IODB_CFG_ADDR_RST  = 32'h0000_0000;
  localparam logic [31:0] IODB_CFG_ADDR_WMSK = 32'h80ff_fffc;
  localparam int          IODB_CFG_EN_BIT    = 31;
  localparam logic [4:0]  IODB_SLOT_USED     = 5'h00;
  localparam logic [2:0]  IODB_FN_HOSTCTL    = 3'h0;
  localparam logic [2:0]  IODB_FN_USBCFG     = 3'h1;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {
    IODB_T_NONE    = 4'h0,
    IODB_T_GPIO_LO = 4'h1,
    IODB_T_PSEL    = 4'h2,
    IODB_T_GPIO_HI = 4'h3,
    IODB_T_PMIRQ   = 4'h4,
    IODB_T_SER     = 4'h5,
    IODB_T_PAR     = 4'h6,
    IODB_T_RSV     = 4'h7,
    IODB_T_PS2     = 4'h8,
    IODB_T_PWM     = 4'h9
  } iodb_target_e;

  // System bus request from the processor side.
  typedef struct packed {
    logic        req;
    logic        wr;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [1:0]  size;    // 0: byte, 1: halfword, 2: word
  } iodb_sreq_s;

  // Internal PCI transaction request.
  typedef struct packed {
    logic        req;
    logic        cfg;     // 1: configuration cycle, 0: memory cycle
    logic        wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } iodb_preq_s;

  // Internal I/O unit request.
  typedef struct packed {
    logic         req;
    logic         wr;
    iodb_target_e tgt;
    logic [7:0]   offs;
    logic [15:0]  wdata;
  } iodb_ioreq_s;

  localparam logic [1:0] IODB_SIZE_HALF = 2'h1;
  localparam logic [1:0] IODB_SIZE_WORD = 2'h2;

endpackage : iodb_pkg

// File: testbench/iodb_bridge_props.sv
/* Checker of the bridge mapping and answers.
   Assumes one request at a time and a bind onto iodb_bridge. */
`timescale 1ns/1ps
module iodb_bridge_props (
  input wire logic                  sys_clk,
  input wire logic                  rst,
  input wire iodb_pkg::iodb_sreq_s  sreq,
  input wire logic                  sdone,
  input wire logic                  serr,
  input wire logic [31:0]           srdata,
  input wire logic [31:0]           mem_base,
  input wire iodb_pkg::iodb_preq_s  preq,
  input wire logic                  pack,
  input wire logic [31:0]           prdata,
  input wire iodb_pkg::iodb_ioreq_s ioreq,
  input wire logic                  ioack,
  input wire logic [15:0]           iordata
);
  import iodb_pkg::*;
  logic [31:0] cfg_r;
  // Shadow of the address register, so data accesses can be judged.
  always_ff @(posedge sys_clk) begin
    if (rst)
      cfg_r <= 32'h0;
    else if (sreq.req && sreq.wr && sreq.addr == IODB_CFG_ADDR_REG && sreq.size == IODB_SIZE_WORD)
      cfg_r <= sreq.wdata & 32'h80ff_fffc;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ---------------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------------
  sequence s_cd; sreq.req && sreq.addr == IODB_CFG_DATA_REG && sreq.size == IODB_SIZE_WORD; endsequence
  sequence s_io; sreq.req && sreq.addr >= IODB_GPIO_LO_BASE && sreq.addr <= IODB_PWM_LAST; endsequence
  sequence s_fail; sdone && serr && !ioreq.req; endsequence
  property p_win; sreq.req && sreq.addr >= {8'h0a, mem_base[23:16], 16'h0} && sreq.addr <= IODB_WIN_LAST |=>
    preq.req && !preq.cfg && preq.addr == {mem_base[31:24], $past(sreq.addr[23:0])}; endproperty
  a_win: assert property (p_win) else $error("window access mapped wrong");
  property p_rsv; s_io ##0 sreq.addr >= IODB_RSV_BASE && sreq.addr <= IODB_RSV_LAST |=> s_fail; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved range not refused");
  property p_io16; s_io ##0 sreq.size != IODB_SIZE_HALF |=> s_fail; endproperty
  a_io16: assert property (p_io16) else $error("wrong width not refused");
  property p_pack; pack && !preq.wr |=> sdone && srdata == $past(prdata); endproperty
  a_pack: assert property (p_pack) else $error("PCI read data lost");
  property p_ioack; ioack && !ioreq.wr |=> sdone && srdata[15:0] == $past(iordata); endproperty
  a_ioack: assert property (p_ioack) else $error("unit read data lost");
  property p_coff; s_cd ##0 !sreq.wr && !cfg_r[31] |=> sdone && !preq.req && srdata == 32'hffff_ffff; endproperty
  a_coff: assert property (p_coff) else $error("cycle while disabled");
  property p_con; s_cd ##0 cfg_r[31] && cfg_r[15:9] == 7'h0 |=>
    preq.req && preq.cfg && preq.wr == $past(sreq.wr) && preq.addr == {21'h0, cfg_r[10:0]}; endproperty
  a_con: assert property (p_con) else $error("config cycle wrong");
  property p_crd; sreq.req && !sreq.wr && sreq.addr == IODB_CFG_ADDR_REG |=> sdone && srdata == cfg_r; endproperty
  a_crd: assert property (p_crd) else $error("address register readback wrong");
  property p_cfn; s_cd ##0 cfg_r[31] && cfg_r[15:9] != 7'h0 |=> sdone && !preq.req; endproperty
  a_cfn: assert property (p_cfn) else $error("unused slot or function reached the PCI side");
endmodule // iodb_bridge_props

bind iodb_bridge iodb_bridge_props iodb_bridge_props_inst (.sys_clk, .rst, .sreq, .sdone, .serr, .srdata,
  .mem_base, .preq, .pack, .prdata, .ioreq, .ioack, .iordata);

// File: testbench/iodb_bridge_tb.sv
/* Self-checking bench of the bridge with the far-side model.
   Assumes the request protocol of one pulse, then a wait for done. */
`timescale 1ns/1ps
module iodb_bridge_tb;
  import iodb_pkg::*;
  localparam logic [1:0]  W = IODB_SIZE_WORD;
  localparam logic [31:0] CA = IODB_CFG_ADDR_REG, CD = IODB_CFG_DATA_REG;
  logic        sys_clk = 1'b0, rst = 1'b1, sdone, serr, pack, ioack;
  logic [31:0] srdata, prdata, rd, mem_base = 32'h3c12_0000;
  logic [15:0] iordata;
  iodb_sreq_s  sreq = '0;
  iodb_preq_s  preq, pl;
  iodb_ioreq_s ioreq, il;
  int          fails = 0, num_checks = 0, np = 0, ni = 0;
  logic [31:0] ad[9] = '{IODB_GPIO_LO_BASE, IODB_PSEL_LAST - 1, IODB_GPIO_HI_BASE, IODB_PMIRQ_LAST - 1,
    IODB_SER_BASE, IODB_PAR_LAST - 1, IODB_RSV_BASE, IODB_PS2_LAST - 1, IODB_PWM_BASE};
  always #5 sys_clk = ~sys_clk;
  iodb_bridge iodb_bridge_inst (.sys_clk, .rst, .sreq, .sdone, .serr, .srdata, .mem_base, .preq, .pack,
    .prdata, .ioreq, .ioack, .iordata);
  iodb_far_model iodb_far_model_inst (.sys_clk, .rst, .preq, .ioreq, .pack, .prdata, .ioack, .iordata);
  always @(posedge sys_clk) begin
    if (preq.req === 1'b1) begin
      np = np + 1;
      pl = preq;
    end
    if (ioreq.req === 1'b1) begin
      ni = ni + 1;
      il = ioreq;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One access: count of far-side requests and the error flag are checked every time.
  task automatic run(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [1:0] s,
                     input int en, input int ee);
    int c;
    c = np + ni;
    @(negedge sys_clk);
    sreq = '{1'b1, w, a, d, s};
    @(negedge sys_clk);
    sreq.req = 1'b0;
    for (int i = 0; i < 20 && sdone !== 1'b1; i++) @(negedge sys_clk);
    rd = srdata;
    chk({30'h0, sdone, serr}, {30'h0, 1'b1, 1'(ee)});
    chk(32'(np + ni - c), 32'(en));
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #20000;
    fails++;
    test_done;
  end
  initial begin
    repeat (12) @(negedge sys_clk);
    rst = 1'b0;
    run(1'b0, CA, 0, W, 0, 0);
    chk(rd, 32'h0);
    run(1'b1, CA, '1, W, 0, 0);
    run(1'b0, CA, 0, W, 0, 0);
    chk(rd, 32'h80ff_fffc);
    run(1'b0, CD, 0, W, 0, 0);
    chk(rd, '1);
    run(1'b1, CA, 32'h0000_0010, W, 0, 0);
    run(1'b0, CD, 0, W, 0, 0);
    chk(rd, '1);
    run(1'b1, CA, 32'h8000_0010, W, 0, 0);
    run(1'b0, CD, 0, W, 1, 0);
    chk({pl.cfg, pl.wr, pl.addr[29:0]}, 32'h8000_0010);
    chk(rd, ~32'h10);
    run(1'b1, CA, 32'h8000_0104, W, 0, 0);
    run(1'b1, CD, 32'h1234_abcd, W, 1, 0);
    chk({pl.cfg, pl.wr, pl.addr[29:0]}, 32'hc000_0104);
    chk(pl.wdata, 32'h1234_abcd);
    run(1'b1, CA, 32'h8000_0204, W, 0, 0);
    run(1'b0, CD, 0, W, 0, 0);
    chk(rd, '1);
    run(1'b0, CD, 0, IODB_SIZE_HALF, 0, 1);
    run(1'b0, 32'h0a12_3456, 0, W, 1, 0);
    chk({pl.cfg, pl.wr, pl.addr[29:0]}, 32'h3c12_3456);
    chk(rd, ~32'h3c12_3456);
    run(1'b1, IODB_WIN_LAST - 3, 32'h5a5a_c3c3, W, 1, 0);
    chk({pl.cfg, pl.wr, pl.addr[29:0]}, 32'h7cfe_fffc);
    chk(pl.wdata, 32'h5a5a_c3c3);
    run(1'b0, 32'h0aff_0000, 0, W, 0, 1);
    run(1'b0, 32'h0a11_fffc, 0, W, 0, 1);
    // A second base value moves the window start and replaces the top address byte.
    mem_base = 32'h5a80_0000;
    run(1'b0, 32'h0a7f_fffe, 0, W, 0, 1);
    run(1'b0, 32'h0a80_0010, 0, W, 1, 0);
    chk(pl.addr, 32'h5a80_0010);
    chk({31'h0, pl.cfg}, 32'h0);
    run(1'b0, IODB_SER_BASE, 0, W, 0, 1);
    run(1'b0, 32'h1500_1100, 0, IODB_SIZE_HALF, 0, 1);
    foreach (ad[k]) begin
      run(1'b0, ad[k], 0, IODB_SIZE_HALF, k == 6 ? 0 : 1, k == 6);
      if (k != 6)
        chk({12'h0, il.tgt, rd[15:0]}, {12'h0, 4'(k + 1), ad[k][7:0], ~ad[k][7:0]});
    end
    run(1'b1, IODB_PAR_BASE + 32'h2, 32'h0000_a55a, IODB_SIZE_HALF, 1, 0);
    chk({il.wr, 3'h0, il.tgt, il.offs, il.wdata}, {1'b1, 3'h0, 4'h6, 8'h22, 16'ha55a});
    chk(rd, 32'h0);
    // A reset in mid-run must bring the address register back to zero.
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    run(1'b0, CA, 0, W, 0, 0);
    chk(rd, 32'h0);
    test_done;
  end
endmodule // iodb_bridge_tb

// File: testbench/iodb_far_model.sv
/* Far-side model: internal PCI target and internal I/O units.
   Assumes the bridge holds request fields until it is answered. */
`timescale 1ns/1ps
module iodb_far_model (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire iodb_pkg::iodb_preq_s  preq,
  input  wire iodb_pkg::iodb_ioreq_s ioreq,
  output logic                       pack,
  output logic [31:0]                prdata,
  output logic                       ioack,
  output logic [15:0]                iordata
);
  import iodb_pkg::*;
  logic [2:0]  pdly_r;
  logic [31:0] junk_r;
  // The PCI side answers three cycles after the request and the units one cycle after, so both waits are exercised.
  always_ff @(posedge sys_clk) begin
    pdly_r <= rst ? 3'h0 : {pdly_r[1:0], preq.req};
    ioack  <= !rst && ioreq.req;
    junk_r <= rst ? 32'h0 : junk_r + 32'h9e37_79b1;
  end
  assign pack    = pdly_r[2];
  // Outside an answer the data lines move, so stale data is never mistaken for a reply.
  assign prdata  = pack ? ~preq.addr : junk_r;
  assign iordata = ioack ? {ioreq.offs, ~ioreq.offs} : junk_r[15:0];
endmodule // iodb_far_model
